// ==== hdl/scb_pkg.sv ====
// scb_pkg: constants and carrier types for the single-clock word buffer.
// assumes a 32-bit apb master on the same clock as the buffer.
package scb_pkg;

  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam int unsigned SCB_ADDR_W     = 8;
  localparam logic [7:0]  SCB_OFF_CTRL   = 8'h00;
  localparam logic [7:0]  SCB_OFF_STAT   = 8'h04;
  localparam logic [7:0]  SCB_OFF_LEVEL  = 8'h08;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned SCB_CTRL_SCLR  = 0;
  localparam int unsigned SCB_CTRL_OVF   = 1;
  localparam int unsigned SCB_CTRL_UDF   = 2;
  localparam int unsigned SCB_STAT_EMPTY = 0;
  localparam int unsigned SCB_STAT_FULL  = 1;
  localparam int unsigned SCB_STAT_AEMP  = 2;
  localparam int unsigned SCB_STAT_AFUL  = 3;
  localparam int unsigned SCB_STAT_CNT   = 16;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic        SCB_RST_OVF    = 1'b1;
  localparam logic        SCB_RST_UDF    = 1'b1;
  localparam logic [31:0] SCB_RST_RDATA  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [SCB_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata;
  } scb_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } scb_apb_rsp_t;

endpackage : scb_pkg

// ==== hdl/scb_fifo.sv ====
// scb_fifo: single-clock first-in first-out word buffer with apb control.
// assumes producer and consumer logic on ref_clk_i; aclr_i may be async.
//
// The APB slave port and the placing of the registers are this design's own decisions.

module scb_fifo
  import scb_pkg::*;
#(
  parameter int unsigned word_width       = 8,
  parameter int unsigned depth_words      = 16,
  parameter string       lookahead_select = "OFF",
  parameter int unsigned almost_full_lvl  = 12,
  parameter int unsigned almost_empty_lvl = 4,
  parameter int unsigned count_width      = $clog2(depth_words)
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   nrst_i,
  input  wire logic                   ce_i,
  input  wire logic                   aclr_i,
  input  wire logic                   sclr_i,
  input  wire logic                   push_i,
  input  wire logic [word_width-1:0]  wdata_i,
  input  wire logic                   pop_i,
  output logic      [word_width-1:0]  rdata_o,
  output logic                        full_o,
  output logic                        empty_o,
  output logic                        almost_full_o,
  output logic                        almost_empty_o,
  output logic      [count_width-1:0] usedw_o,
  input  wire scb_apb_req_t           apb_i,
  output scb_apb_rsp_t                apb_o
);

  localparam int unsigned AW = count_width;
  localparam bit SHOW_AHEAD = (lookahead_select == "ON");
  localparam logic [AW:0] DEPTH_F = (AW+1)'(depth_words);
  localparam logic [AW:0] AF_LVL  = (AW+1)'(almost_full_lvl);
  localparam logic [AW:0] AE_LVL  = (AW+1)'(almost_empty_lvl);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if ((depth_words & (depth_words - 1)) != 0) begin : g_pow2
    $error("depth_words must be a power of two");
  end
  if (depth_words < 4) begin : g_min
    $error("depth_words must be at least four");
  end
  if (count_width != $clog2(depth_words)) begin : g_cw
    $error("count_width must be clog2 of depth_words");
  end

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   fill;
    logic          full;
    logic          empty;
    logic          afull;
    logic          aempty;
  } scb_buf_t;

  typedef struct packed {
    logic [word_width-1:0] q;
    logic                  ovf_chk;
    logic                  udf_chk;
    scb_apb_rsp_t          rsp;
  } scb_out_t;

  typedef struct packed {
    scb_buf_t b;
    scb_out_t o;
  } scb_state_t;

  // ----------------------------------------------------------------
  // reset release and clear
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;
  logic clr_n;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // buffer side also cleared at once by the async clear
  assign clr_n = rst_n_r & ~aclr_i;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [word_width-1:0] mem [depth_words];

  scb_state_t st_r;
  scb_state_t st_nxt;
  // buffer and output halves keep separate resets, one process each
  scb_buf_t   buf_r;
  scb_out_t   out_r;

  assign st_r = '{b: buf_r, o: out_r};
  logic       wr_go;
  logic       rd_go;
  logic       clear;

  always_ff @(posedge ref_clk_i) begin
    if (ce_i && wr_go) begin
      mem[st_r.b.wr_ptr] <= wdata_i;
    end
  end

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = p + 1'b1; // wraps because depth is a power of two
  endfunction : ptr_inc

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic          apb_acc;
  logic          apb_done;
  logic [7:0]    addr;
  logic [AW-1:0] head_idx;
  logic [31:0]   rd_word;
  logic          rd_err;

  always_comb begin
    st_nxt   = st_r;
    addr     = apb_i.paddr;
    apb_acc  = apb_i.psel & apb_i.penable;
    apb_done = apb_acc & st_r.o.rsp.pready;

    // software sync clear takes effect at the completing edge
    clear = sclr_i | (apb_done & apb_i.pwrite & (addr == SCB_OFF_CTRL)
            & apb_i.pwdata[SCB_CTRL_SCLR]);

    // protected requests; the far side drops them on the flag
    wr_go = push_i & ~(st_r.b.full & st_r.o.ovf_chk) & ~clear;
    rd_go = pop_i & ~(st_r.b.empty & st_r.o.udf_chk) & ~clear;

    if (clear) begin
      st_nxt.b.wr_ptr = '0;
      st_nxt.b.rd_ptr = '0;
      st_nxt.b.fill   = '0;
    end else begin
      if (wr_go) begin
        st_nxt.b.wr_ptr = ptr_inc(st_r.b.wr_ptr);
      end
      if (rd_go) begin
        st_nxt.b.rd_ptr = ptr_inc(st_r.b.rd_ptr);
      end
      case ({wr_go, rd_go})
        2'b10:   st_nxt.b.fill = st_r.b.fill + 1'b1;
        2'b01:   st_nxt.b.fill = st_r.b.fill - 1'b1;
        default: st_nxt.b.fill = st_r.b.fill;
      endcase
    end

    // flags follow the next fill count
    st_nxt.b.full   = (st_nxt.b.fill == DEPTH_F);
    st_nxt.b.empty  = (st_nxt.b.fill == '0);
    st_nxt.b.afull  = (st_nxt.b.fill >= AF_LVL);
    st_nxt.b.aempty = (st_nxt.b.fill < AE_LVL);

    // read output
    head_idx = st_nxt.b.rd_ptr;
    if (SHOW_AHEAD) begin
      // keep the oldest word presented; bypass a word written this edge
      if (!clear && st_nxt.b.fill != '0) begin
        if (wr_go && head_idx == st_r.b.wr_ptr) begin
          st_nxt.o.q = wdata_i;
        end else begin
          st_nxt.o.q = mem[head_idx];
        end
      end
    end else if (rd_go) begin
      st_nxt.o.q = mem[st_r.b.rd_ptr];
    end

    // apb slave: one wait state, answer registered
    rd_word = '0;
    rd_err  = 1'b0;
    case (addr)
      SCB_OFF_CTRL: begin
        rd_word[SCB_CTRL_OVF] = st_r.o.ovf_chk;
        rd_word[SCB_CTRL_UDF] = st_r.o.udf_chk;
      end
      SCB_OFF_STAT: begin
        rd_word[SCB_STAT_EMPTY] = st_r.b.empty;
        rd_word[SCB_STAT_FULL]  = st_r.b.full;
        rd_word[SCB_STAT_AEMP]  = st_r.b.aempty;
        rd_word[SCB_STAT_AFUL]  = st_r.b.afull;
        rd_word[SCB_STAT_CNT +: AW] = st_r.b.fill[AW-1:0];
      end
      SCB_OFF_LEVEL: begin
        rd_word[AW:0] = {st_r.b.full, st_r.b.fill[AW-1:0]};
      end
      default: rd_err = 1'b1;
    endcase

    st_nxt.o.rsp.pready  = apb_acc & ~st_r.o.rsp.pready;
    st_nxt.o.rsp.pslverr = apb_acc & ~st_r.o.rsp.pready & rd_err;
    if (apb_acc && !st_r.o.rsp.pready && !apb_i.pwrite) begin
      st_nxt.o.rsp.prdata = rd_word;
    end else if (!apb_acc) begin
      st_nxt.o.rsp.prdata = SCB_RST_RDATA;
    end
    if (apb_done && apb_i.pwrite && addr == SCB_OFF_CTRL) begin
      st_nxt.o.ovf_chk = apb_i.pwdata[SCB_CTRL_OVF];
      st_nxt.o.udf_chk = apb_i.pwdata[SCB_CTRL_UDF];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // buffer state honours the async clear; output word does not
  always_ff @(posedge ref_clk_i or negedge clr_n) begin
    if (!clr_n) begin
      buf_r.wr_ptr <= '0;
      buf_r.rd_ptr <= '0;
      buf_r.fill   <= '0;
      buf_r.full   <= 1'b0;
      buf_r.empty  <= 1'b1;
      buf_r.afull  <= 1'b0;
      buf_r.aempty <= 1'b1;
    end else if (ce_i) begin
      buf_r <= st_nxt.b;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      out_r.q       <= '0;
      out_r.ovf_chk <= SCB_RST_OVF;
      out_r.udf_chk <= SCB_RST_UDF;
      out_r.rsp     <= '0;
    end else if (ce_i) begin
      out_r <= st_nxt.o;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o        = st_r.o.q;
  assign full_o         = st_r.b.full;
  assign empty_o        = st_r.b.empty;
  assign almost_full_o  = st_r.b.afull;
  assign almost_empty_o = st_r.b.aempty;
  assign usedw_o        = st_r.b.fill[AW-1:0];
  assign apb_o          = st_r.o.rsp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!clr_n);

  full_tracks_fill_a: assert property (
    full_o == (st_r.b.fill == DEPTH_F))
    else $error("full does not match occupancy");

  count_wraps_a: assert property (
    full_o |-> (usedw_o == '0))
    else $error("fill count not zero while full");

  overflow_ignore_a: assert property (
    (ce_i && full_o && push_i && !pop_i && st_r.o.ovf_chk && !clear)
    |=> (full_o && $stable(st_r.b.wr_ptr)))
    else $error("write accepted while full");

  underflow_ignore_a: assert property (
    (ce_i && empty_o && pop_i && !push_i && st_r.o.udf_chk && !clear)
    |=> (empty_o && $stable(st_r.b.rd_ptr)))
    else $error("read accepted while empty");

  push_counts_a: assert property (
    (ce_i && wr_go && !rd_go) |=> (st_r.b.fill == $past(st_r.b.fill) + 1'b1))
    else $error("accepted write did not raise count");

  both_hold_a: assert property (
    (ce_i && wr_go && rd_go) |=> $stable(st_r.b.fill))
    else $error("read and write changed count");

  almost_full_a: assert property (
    almost_full_o == (st_r.b.fill >= AF_LVL))
    else $error("almost full mismatch");

  almost_empty_a: assert property (
    almost_empty_o == (st_r.b.fill < AE_LVL))
    else $error("almost empty mismatch");

  sync_clear_a: assert property (
    (ce_i && sclr_i) |=> (empty_o && !full_o && $stable(rdata_o)))
    else $error("sync clear did not empty buffer");

  legacy_read_a: assert property (
    (!SHOW_AHEAD && ce_i && rd_go) |=> (rdata_o == $past(mem[st_r.b.rd_ptr])))
    else $error("legacy read word wrong");

  show_head_a: assert property (
    (SHOW_AHEAD && !empty_o && !$past(sclr_i) && $past(ce_i))
    |-> (rdata_o == mem[st_r.b.rd_ptr]))
    else $error("shown word is not the oldest");

  ce_hold_a: assert property (
    (!ce_i) |=> ($stable(st_r.b.wr_ptr) && $stable(st_r.b.fill)))
    else $error("state moved while clock enable low");

  empty_tracks_a: assert property (
    empty_o == (st_r.b.fill == '0))
    else $error("empty does not match occupancy");

  pop_counts_a: assert property (
    (ce_i && rd_go && !wr_go) |=> (st_r.b.fill == $past(st_r.b.fill) - 1'b1))
    else $error("accepted read did not lower count");

  clear_empties_a: assert property (
    (ce_i && clear) |=> (empty_o && !full_o && !almost_full_o && usedw_o == '0))
    else $error("clear did not empty buffer");

  fill_bound_a: assert property (
    st_r.o.ovf_chk |-> (st_r.b.fill <= DEPTH_F))
    else $error("count beyond depth with overflow check on");

  show_write_a: assert property (
    (SHOW_AHEAD && ce_i && empty_o && wr_go && !rd_go)
    |=> (rdata_o == $past(wdata_i)))
    else $error("first word not shown after write into empty");

  legacy_hold_a: assert property (
    (!SHOW_AHEAD && ce_i && !rd_go) |=> $stable(rdata_o))
    else $error("legacy output changed without a read");

  pready_pulse_a: assert property (
    apb_o.pready |=> !apb_o.pready)
    else $error("ready held longer than one cycle");

endmodule : scb_fifo

// ==== testbench/scb_feed.sv ====
// scb_feed: producer and consumer logic facing the buffer.
// assumes the same clock as the buffer; gating is combinational.
module scb_feed (
  input  wire logic want_push_i,
  input  wire logic want_pop_i,
  input  wire logic rude_i,
  input  wire logic full_i,
  input  wire logic empty_i,
  output logic      push_o,
  output logic      pop_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // flags used unregistered; rude_i ignores them
  assign push_o = want_push_i & (rude_i | ~full_i);
  assign pop_o  = want_pop_i & (rude_i | ~empty_i);
endmodule : scb_feed

// ==== testbench/tb_scb_fifo.sv ====
// tb_scb_fifo: self-checking bench, legacy and show-ahead copies.
// assumes the apb answers with one wait state.
module tb_scb_fifo;
  import scb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic p, q; logic [7:0] d; logic e, f; logic [1:0] c;
    logic af, ae, ck; logic [7:0] r, sa;
  } scb_row_t;
  logic ref_clk, nrst_n, aclr, sclr, wp, wq, rude, push, pop, ce;
  logic afull_sa, aempty_sa;
  logic [1:0] usedw_sa;
  logic [7:0] wdata, rdata, rdata_sa;
  logic full, empty, afull, aempty, full_sa, empty_sa;
  logic [1:0] usedw;
  logic [31:0] rd;
  logic err;
  scb_apb_req_t req;
  scb_apb_rsp_t rsp;
  scb_row_t rows [9];
  int n_errors = 0;
  int tests_run = 0;
  scb_feed feed (.want_push_i(wp), .want_pop_i(wq), .rude_i(rude), .full_i(full),
                 .empty_i(empty), .push_o(push), .pop_o(pop));
  scb_fifo #(.word_width(8), .depth_words(4), .almost_full_lvl(3), .almost_empty_lvl(2))
    dut (.ref_clk_i(ref_clk), .nrst_i(nrst_n), .ce_i(ce), .aclr_i(aclr), .sclr_i(sclr),
         .push_i(push), .wdata_i(wdata), .pop_i(pop), .rdata_o(rdata), .full_o(full),
         .empty_o(empty), .almost_full_o(afull), .almost_empty_o(aempty), .usedw_o(usedw),
         .apb_i(req), .apb_o(rsp));
  scb_fifo #(.word_width(8), .depth_words(4), .lookahead_select("ON"), .almost_full_lvl(3),
             .almost_empty_lvl(2))
    dut_sa (.ref_clk_i(ref_clk), .nrst_i(nrst_n), .ce_i(ce), .aclr_i(aclr),
            .sclr_i(sclr), .push_i(push), .wdata_i(wdata), .pop_i(pop), .rdata_o(rdata_sa),
            .full_o(full_sa), .empty_o(empty_sa), .almost_full_o(afull_sa),
            .almost_empty_o(aempty_sa), .usedw_o(usedw_sa), .apb_i('0), .apb_o());
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic step(input logic p, input logic q, input logic [7:0] d, input logic ru);
    @(posedge ref_clk);
    wp <= p; wq <= q; wdata <= d; rude <= ru;
    @(posedge ref_clk);
    wp <= 1'b0; wq <= 1'b0; rude <= 1'b0;
    #1;
  endtask : step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    // ready and data as the slave saw them at this edge
    do begin
      @(posedge ref_clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    #1;
  endtask : apb
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  // ------------------------------------------------------------
  // clock, watchdog, sequence
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    #20000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    nrst_n = 1'b0; aclr = 1'b0; sclr = 1'b0; wp = 1'b0; wq = 1'b0; rude = 1'b0;
    wdata = '0; req = '0; ce = 1'b1;
    rows[0] = '{1,0,8'h11,0,0,2'd1,0,1,0,8'h00,8'h00};
    rows[1] = '{1,0,8'h22,0,0,2'd2,0,0,1,8'h00,8'h11};
    rows[2] = '{1,0,8'h33,0,0,2'd3,1,0,1,8'h00,8'h11};
    rows[3] = '{1,0,8'h44,0,1,2'd0,0,0,0,8'h00,8'h11};
    rows[4] = '{0,1,8'h00,0,0,2'd3,1,0,1,8'h11,8'h22};
    rows[5] = '{1,1,8'h55,0,0,2'd3,1,0,1,8'h22,8'h33};
    rows[6] = '{0,1,8'h00,0,0,2'd2,0,0,1,8'h33,8'h44};
    rows[7] = '{0,1,8'h00,0,0,2'd1,0,1,1,8'h44,8'h55};
    rows[8] = '{0,1,8'h00,1,0,2'd0,0,1,1,8'h55,8'h55};
    repeat (12) @(posedge ref_clk);
    nrst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    foreach (rows[i]) begin
      step(rows[i].p, rows[i].q, rows[i].d, 1'b0);
      chk("empty", 32'(empty), 32'(rows[i].e));
      chk("full", 32'(full), 32'(rows[i].f));
      chk("usedw", 32'(usedw), 32'(rows[i].c));
      chk("usedw_sa", 32'(usedw_sa), 32'(rows[i].c));
      chk("empty_sa", 32'(empty_sa), 32'(rows[i].e));
      chk("full_sa", 32'(full_sa), 32'(rows[i].f));
      chk("rdata", 32'(rdata), 32'(rows[i].r));
      if (rows[i].ck) begin
        chk("almost_full", 32'(afull), 32'(rows[i].af));
        chk("almost_empty", 32'(aempty), 32'(rows[i].ae));
        chk("rdata_sa", 32'(rdata_sa), 32'(rows[i].sa));
        chk("almost_full_sa", 32'(afull_sa), 32'(rows[i].af));
        chk("almost_empty_sa", 32'(aempty_sa), 32'(rows[i].ae));
      end
    end
    $display("test rows done");
    for (int k = 0; k < 4; k++) step(1'b1, 1'b0, 8'ha0 + 8'(k), 1'b0);
    apb(1'b0, SCB_OFF_LEVEL, '0);
    chk("level", rd, 32'h4);
    apb(1'b0, SCB_OFF_STAT, '0);
    chk("stat_full", 32'(rd[SCB_STAT_FULL]), 32'h1);
    step(1'b1, 1'b0, 8'h99, 1'b1);
    apb(1'b0, SCB_OFF_LEVEL, '0);
    chk("level_ovf", rd, 32'h4);
    step(1'b0, 1'b1, 8'h00, 1'b0);
    chk("rdata_ovf", 32'(rdata), 32'ha0);
    apb(1'b0, 8'h0c, '0);
    chk("pslverr", 32'(err), 32'h1);
    chk("prdata", rd, 32'h0);
    $display("test overflow done");
    apb(1'b1, SCB_OFF_CTRL, 32'h7);
    chk("empty_sclr", 32'(empty), 32'h1);
    chk("rdata_sclr", 32'(rdata), 32'ha0);
    step(1'b0, 1'b1, 8'h00, 1'b1);
    chk("empty_udf", 32'(empty), 32'h1);
    chk("usedw_udf", 32'(usedw), 32'h0);
    chk("rdata_udf", 32'(rdata), 32'ha0);
    $display("test underflow done");
    step(1'b1, 1'b0, 8'hb0, 1'b0);
    @(posedge ref_clk);
    sclr <= 1'b1;
    @(posedge ref_clk);
    sclr <= 1'b0;
    #1;
    chk("empty_pin", 32'(empty), 32'h1);
    step(1'b1, 1'b0, 8'hc0, 1'b0);
    @(posedge ref_clk);
    aclr <= 1'b1;
    #1;
    chk("empty_aclr", 32'(empty), 32'h1);
    chk("rdata_aclr", 32'(rdata), 32'ha0);
    @(posedge ref_clk);
    aclr <= 1'b0;
    $display("test clears done");
    ce <= 1'b0;
    step(1'b1, 1'b0, 8'he0, 1'b0);
    ce <= 1'b1;
    chk("empty_ce", 32'(empty), 32'h1);
    chk("usedw_ce", 32'(usedw), 32'h0);
    $display("test enable done");
    step(1'b1, 1'b0, 8'hd0, 1'b0);
    @(posedge ref_clk);
    nrst_n <= 1'b0;
    #1;
    chk("empty_rst", 32'(empty), 32'h1);
    chk("usedw_rst", 32'(usedw), 32'h0);
    chk("rdata_rst", 32'(rdata), 32'h0);
    repeat (3) @(posedge ref_clk);
    nrst_n <= 1'b1;
    $display("test reset done");
    tally_and_finish();
  end
endmodule : tb_scb_fifo
